// file: rtl/dbc_consts.vh
// Purpose: shared constants of the debug command and cpu handshake block
// Assumes: plain Verilog-2005, included by bare name
// Notes: tap states are one-hot codes
`ifndef DBC_CONSTS_VH
`define DBC_CONSTS_VH
// tap controller states, one-hot
`define DBC_ST_W 16
`define DBC_ST_TLR 16'h0001
`define DBC_ST_RTI 16'h0002
`define DBC_ST_SELDR 16'h0004
`define DBC_ST_CAPDR 16'h0008
`define DBC_ST_SHDR 16'h0010
`define DBC_ST_EX1DR 16'h0020
`define DBC_ST_PADR 16'h0040
`define DBC_ST_EX2DR 16'h0080
`define DBC_ST_UPDR 16'h0100
`define DBC_ST_SELIR 16'h0200
`define DBC_ST_CAPIR 16'h0400
`define DBC_ST_SHIR 16'h0800
`define DBC_ST_EX1IR 16'h1000
`define DBC_ST_PAIR 16'h2000
`define DBC_ST_EX2IR 16'h4000
`define DBC_ST_UPIR 16'h8000
// command register layout
`define DBC_CMD_W 8
`define DBC_CMD_RD 7
`define DBC_CMD_GO 6
`define DBC_CMD_EXIT 5
`define DBC_SEL_HI 4
`define DBC_SEL_LO 0
`define DBC_CMD_RST 8'h0c
`define DBC_IR_CAPTURE 8'h01
// register select codes
`define DBC_SEL_TRACE 5'h03
`define DBC_SEL_CNT_A 5'h04
`define DBC_SEL_CNT_B 5'h05
`define DBC_SEL_PCFIFO 5'h06
`define DBC_SEL_BASE_A 5'h07
`define DBC_SEL_BASE_B 5'h08
`define DBC_SEL_MASK_A 5'h09
`define DBC_SEL_MASK_B 5'h0a
`define DBC_SEL_CPU_SCAN_REGISTER 5'h0b
`define DBC_SEL_BYPASS 5'h0c
`define DBC_SEL_CTRL 5'h0d
`define DBC_SEL_STAT 5'h0e
// data width and debug control register fields
`define DBC_DW 32
`define DBC_CTRL_RST 32'h00000000
`define DBC_CTRL_SOFT 15
`define DBC_CTRL_IHR_EN 14
`define DBC_CTRL_TRACE_EN 13
`define DBC_CTRL_RCB 11
`define DBC_CTRL_BCB_HI 10
`define DBC_CTRL_BCB_LO 6
`define DBC_CTRL_RCA 5
`define DBC_CTRL_BCA_HI 4
`define DBC_CTRL_BCA_LO 0
// breakpoint qualifier field: low three bits kind, high two bits mode
`define DBC_BC_OFF 5'h00
`define DBC_BK_ANY 3'h1
`define DBC_BK_INSTR 3'h2
`define DBC_BK_DATA 3'h3
`define DBC_BK_COF 3'h4
`define DBC_BK_WRITE 3'h5
`define DBC_BK_READ 3'h6
`define DBC_BM_ANY 2'h0
`define DBC_BM_USER 2'h2
`define DBC_BM_SUPER 2'h3
// cpu access attribute bits
`define DBC_AT_W 4
`define DBC_AT_INSTR 0
`define DBC_AT_WRITE 1
`define DBC_AT_SUPER 2
`define DBC_AT_COF 3
// trace counter
`define DBC_TRACE_W 16
`define DBC_TRACE_RST 16'h0000
`define DBC_TRACE_ONE 16'h0001
`define DBC_PS_W 4
`define DBC_PS_EXEC 4'h2
// debug status register bits
`define DBC_STAT_W 6
`define DBC_STAT_RST 6'h00
`define DBC_FLG_RST 4'h0
`endif

// file: rtl/dbc_sync.v
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to clk_sys_i
// Notes: level changes only when stages two and three agree
`timescale 1ns/10ps
module dbc_sync #(
  parameter WIDTH = 4
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] level_o
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  reg [WIDTH-1:0] level;
  genvar g;

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // stage1 is read only by stage2
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
          stage3[g] <= 1'b0;
          level[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          if (stage2[g] == stage3[g]) begin
            level[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

  assign level_o = level;
endmodule // dbc_sync

// file: rtl/dbc_tap_fsm.v
// Purpose: sixteen-state tap controller stepped by sampled tck edges
// Assumes: tck_rise_i is a one-cycle pulse of clk_sys_i
// Notes: trst_n_i low forces test logic reset
`timescale 1ns/10ps
`include "dbc_consts.vh"
module dbc_tap_fsm (
  input wire clk_sys_i,
  input wire rst_i,
  input wire tck_rise_i,
  input wire tms_i,
  input wire trst_n_i,
  output reg [`DBC_ST_W-1:0] state_o
);
  reg [`DBC_ST_W-1:0] next_state;

  // standard transition table
  always @* begin
    case (state_o)
      `DBC_ST_TLR: next_state = tms_i ? `DBC_ST_TLR : `DBC_ST_RTI;
      `DBC_ST_RTI: next_state = tms_i ? `DBC_ST_SELDR : `DBC_ST_RTI;
      `DBC_ST_SELDR: next_state = tms_i ? `DBC_ST_SELIR : `DBC_ST_CAPDR;
      `DBC_ST_CAPDR: next_state = tms_i ? `DBC_ST_EX1DR : `DBC_ST_SHDR;
      `DBC_ST_SHDR: next_state = tms_i ? `DBC_ST_EX1DR : `DBC_ST_SHDR;
      `DBC_ST_EX1DR: next_state = tms_i ? `DBC_ST_UPDR : `DBC_ST_PADR;
      `DBC_ST_PADR: next_state = tms_i ? `DBC_ST_EX2DR : `DBC_ST_PADR;
      `DBC_ST_EX2DR: next_state = tms_i ? `DBC_ST_UPDR : `DBC_ST_SHDR;
      `DBC_ST_UPDR: next_state = tms_i ? `DBC_ST_SELDR : `DBC_ST_RTI;
      `DBC_ST_SELIR: next_state = tms_i ? `DBC_ST_TLR : `DBC_ST_CAPIR;
      `DBC_ST_CAPIR: next_state = tms_i ? `DBC_ST_EX1IR : `DBC_ST_SHIR;
      `DBC_ST_SHIR: next_state = tms_i ? `DBC_ST_EX1IR : `DBC_ST_SHIR;
      `DBC_ST_EX1IR: next_state = tms_i ? `DBC_ST_UPIR : `DBC_ST_PAIR;
      `DBC_ST_PAIR: next_state = tms_i ? `DBC_ST_EX2IR : `DBC_ST_PAIR;
      `DBC_ST_EX2IR: next_state = tms_i ? `DBC_ST_UPIR : `DBC_ST_SHIR;
      `DBC_ST_UPIR: next_state = tms_i ? `DBC_ST_SELDR : `DBC_ST_RTI;
      default: next_state = `DBC_ST_TLR;
    endcase
  end

  // state advances only on a sampled tck rising edge
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_o <= `DBC_ST_TLR;
    end else if (!trst_n_i) begin
      state_o <= `DBC_ST_TLR;
    end else if (tck_rise_i) begin
      state_o <= next_state;
    end
  end
endmodule // dbc_tap_fsm

// file: rtl/dbc_top.v
// Purpose: debug command register, tap data path and cpu halt handshake
// Assumes: clk_sys_i is the processor clock at 40 MHz; tck much slower
// Notes: tap pins are sampled, not used as clocks; cpu side is same clock
`timescale 1ns/10ps
`include "dbc_consts.vh"
// What this block does
// - enabled internal halt input acts like soft halt bit; else ignored
// - halt request asks cpu to finish instruction and enter debug mode
// - halt request also wakes device from stop, doze or wait
// - break request raised when current access meets breakpoint condition
// - breakpoint match uses access address and cycle-type attributes
// - trace counter decrements only on qualifying cpu activity status
// - session set on first debug entry, cleared by go+exit to scan/bypass; code clears for bypass code 0c, not 1f
// - session stays set across single-step exits and re-entries
// - command register: 8-bit shift-ir register, loaded entering update-ir
// - access, step and exit happen only via a dr scan through update-dr
// - bit7 read/write, bit6 go, bit5 exit, bits4-0 register select
// - go runs scanned instruction then returns to debug unless exit set
// - go acts only for cpu scan register or bypass selection; code accepts bypass code 0c but not 1f
// - exit acts only with go and cpu scan or bypass selection; code accepts bypass code 0c but not 1f
// - go or exit takes effect only on entering update-dr
// - codes 03 trace, 04/05 break counters, 06 pc history fifo
// - codes 07/08 break bases a/b, 09/0a break masks a/b
// - 0b cpu scan, 0c and 1f bypass, 0d control, 0e status
// - command selects the data register used in capture, shift, update-dr
module dbc_top (
  input wire clk_sys_i,
  input wire rst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire trst_n_i,
  input wire internal_halt_request_n_i,
  input wire cpu_halt_ack_i,
  input wire cpu_access_valid_i,
  input wire [`DBC_DW-1:0] cpu_addr_i,
  input wire [`DBC_AT_W-1:0] cpu_access_attributes_i,
  input wire [`DBC_PS_W-1:0] cpu_activity_status_i,
  input wire [`DBC_DW-1:0] res_rdata_i,
  output reg tdo_o,
  output reg tdo_oe_n_o,
  output reg cpu_halt_request_o,
  output reg lowpower_wake_o,
  output reg cpu_break_request_o,
  output reg debug_session_o,
  output reg cpu_go_o,
  output reg cpu_go_exit_o,
  output reg [`DBC_SEL_HI:0] res_sel_o,
  output reg res_capture_o,
  output reg res_write_o,
  output reg [`DBC_DW-1:0] res_wdata_o
);
  wire [3:0] pin_s;
  wire [`DBC_ST_W-1:0] tap_st;
  reg [`DBC_ST_W-1:0] tap_st_d;
  wire [`DBC_ST_W-1:0] st_enter;
  reg tck_d;
  wire tck_rise;
  wire tck_fall;
  reg [`DBC_CMD_W-1:0] ir_sh;
  reg [`DBC_CMD_W-1:0] debug_command_reg;
  reg [`DBC_DW-1:0] dr_sh;
  reg [`DBC_DW-1:0] capture_val;
  reg [`DBC_DW-1:0] debug_control_reg;
  reg [`DBC_DW-1:0] break_base_a;
  reg [`DBC_DW-1:0] break_base_b;
  reg [`DBC_DW-1:0] break_mask_a;
  reg [`DBC_DW-1:0] break_mask_b;
  reg [`DBC_TRACE_W-1:0] trace_counter;
  reg ack_d;
  reg brk_seen;
  reg [3:0] cause_flags;
  wire [`DBC_SEL_HI:0] sel;
  wire is_read;
  wire in_tlr;
  wire upd_dr;
  wire go_now;
  wire go_exit_now;
  wire ack_rise;
  wire soft_halt_request_bit;
  wire ihr_active;
  wire trace_hit;
  wire halt_src;
  wire hit_a;
  wire hit_b;
  wire [`DBC_STAT_W-1:0] debug_status_reg;

  // selections that behave as the one-bit bypass register
  function sel_is_bypass;
    input [`DBC_SEL_HI:0] s;
    begin
      sel_is_bypass = (s < `DBC_SEL_TRACE) || (s > `DBC_SEL_STAT) ||
        (s == `DBC_SEL_BYPASS);
    end
  endfunction

  // resources that live outside this block, reached over the res port
  function sel_is_external;
    input [`DBC_SEL_HI:0] s;
    begin
      sel_is_external = (s == `DBC_SEL_CNT_A) || (s == `DBC_SEL_CNT_B) ||
        (s == `DBC_SEL_PCFIFO) || (s == `DBC_SEL_CPU_SCAN_REGISTER);
    end
  endfunction

  // attribute qualifier of one memory breakpoint
  function cpu_access_attributes_ok;
    input [4:0] bc;
    input [`DBC_AT_W-1:0] at;
    reg kind_ok;
    reg mode_ok;
    begin
      case (bc[2:0])
        `DBC_BK_ANY: kind_ok = 1'b1;
        `DBC_BK_INSTR: kind_ok = at[`DBC_AT_INSTR];
        `DBC_BK_DATA: kind_ok = ~at[`DBC_AT_INSTR];
        `DBC_BK_COF: kind_ok = at[`DBC_AT_INSTR] & at[`DBC_AT_COF];
        `DBC_BK_WRITE: kind_ok = ~at[`DBC_AT_INSTR] & at[`DBC_AT_WRITE];
        `DBC_BK_READ: kind_ok = ~at[`DBC_AT_INSTR] & ~at[`DBC_AT_WRITE];
        default: kind_ok = 1'b0;
      endcase
      case (bc[4:3])
        `DBC_BM_ANY: mode_ok = 1'b1;
        `DBC_BM_USER: mode_ok = ~at[`DBC_AT_SUPER];
        `DBC_BM_SUPER: mode_ok = at[`DBC_AT_SUPER];
        default: mode_ok = 1'b0;
      endcase
      cpu_access_attributes_ok = (bc != `DBC_BC_OFF) & kind_ok & mode_ok;
    end
  endfunction

  // tap pins come from the probe's domain: three-flop filtered levels
  dbc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({trst_n_i, tdi_i, tms_i, tck_i}),
    .level_o(pin_s)
  );

  dbc_tap_fsm u_fsm (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tck_rise_i(tck_rise),
    .tms_i(pin_s[1]),
    .trst_n_i(pin_s[3]),
    .state_o(tap_st)
  );

  // tck edges and state entry pulses, all on the system clock
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tck_d <= 1'b0;
      tap_st_d <= `DBC_ST_TLR;
      ack_d <= 1'b0;
    end else begin
      tck_d <= pin_s[0];
      tap_st_d <= tap_st;
      ack_d <= cpu_halt_ack_i;
    end
  end

  assign tck_rise = pin_s[0] & ~tck_d;
  assign tck_fall = ~pin_s[0] & tck_d;
  assign st_enter = tap_st & ~tap_st_d;
  assign in_tlr = |(tap_st & `DBC_ST_TLR);
  assign upd_dr = |(st_enter & `DBC_ST_UPDR);
  assign ack_rise = cpu_halt_ack_i & ~ack_d;

  // command fields
  assign sel = debug_command_reg[`DBC_SEL_HI:`DBC_SEL_LO];
  assign is_read = debug_command_reg[`DBC_CMD_RD];
  // go only for the scan selection (0b) or bypass code 0c, not other bypass codes, only at update-dr
  assign go_now = upd_dr & debug_command_reg[`DBC_CMD_GO] &
    ((sel == `DBC_SEL_CPU_SCAN_REGISTER) || (sel == `DBC_SEL_BYPASS));
  assign go_exit_now = go_now & debug_command_reg[`DBC_CMD_EXIT];

  // instruction path: shift lsb first, load command entering update-ir
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ir_sh <= `DBC_IR_CAPTURE;
      debug_command_reg <= `DBC_CMD_RST;
    end else begin
      if (tck_rise && |(tap_st & `DBC_ST_CAPIR)) begin
        ir_sh <= `DBC_IR_CAPTURE;
      end else if (tck_rise && |(tap_st & `DBC_ST_SHIR)) begin
        ir_sh <= {pin_s[2], ir_sh[`DBC_CMD_W-1:1]};
      end
      if (in_tlr) begin
        debug_command_reg <= `DBC_CMD_RST;
      end else if (|(st_enter & `DBC_ST_UPIR)) begin
        debug_command_reg <= ir_sh;
      end
    end
  end

  // read value for the selected internal resource
  always @* begin
    case (sel)
      `DBC_SEL_TRACE: capture_val = {{(`DBC_DW-`DBC_TRACE_W){1'b0}},
        trace_counter};
      `DBC_SEL_BASE_A: capture_val = break_base_a;
      `DBC_SEL_BASE_B: capture_val = break_base_b;
      `DBC_SEL_MASK_A: capture_val = break_mask_a;
      `DBC_SEL_MASK_B: capture_val = break_mask_b;
      `DBC_SEL_CTRL: capture_val = debug_control_reg;
      `DBC_SEL_STAT: capture_val = {{(`DBC_DW-`DBC_STAT_W){1'b0}},
        debug_status_reg};
      default: capture_val = res_rdata_i;
    endcase
  end

  // data path: the command picks which register the dr scan reaches
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dr_sh <= {`DBC_DW{1'b0}};
    end else if (tck_rise && |(tap_st & `DBC_ST_CAPDR)) begin
      if (sel_is_bypass(sel)) begin
        dr_sh <= {`DBC_DW{1'b0}};
      end else begin
        dr_sh <= capture_val;
      end
    end else if (tck_rise && |(tap_st & `DBC_ST_SHDR)) begin
      if (sel_is_bypass(sel)) begin
        dr_sh <= {{(`DBC_DW-1){1'b0}}, pin_s[2]};
      end else begin
        dr_sh <= {pin_s[2], dr_sh[`DBC_DW-1:1]};
      end
    end
  end

  // tdo changes on tck falling edge, driven only in the shift states
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      if (|(tap_st & `DBC_ST_SHIR)) begin
        tdo_o <= ir_sh[0];
        tdo_oe_n_o <= 1'b0;
      end else if (|(tap_st & `DBC_ST_SHDR)) begin
        tdo_o <= dr_sh[0];
        tdo_oe_n_o <= 1'b0;
      end else begin
        tdo_oe_n_o <= 1'b1;
      end
    end
  end

  // access strobes toward resources outside this block
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      res_sel_o <= `DBC_SEL_BYPASS;
      res_capture_o <= 1'b0;
      res_write_o <= 1'b0;
      res_wdata_o <= {`DBC_DW{1'b0}};
    end else begin
      res_sel_o <= sel;
      res_capture_o <= |(st_enter & `DBC_ST_CAPDR) & is_read &
        sel_is_external(sel);
      res_write_o <= upd_dr & ~is_read & sel_is_external(sel);
      if (upd_dr) begin
        res_wdata_o <= dr_sh;
      end
    end
  end

  // internal registers written at update-dr; test logic reset clears control
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      debug_control_reg <= `DBC_CTRL_RST;
      break_base_a <= {`DBC_DW{1'b0}};
      break_base_b <= {`DBC_DW{1'b0}};
      break_mask_a <= {`DBC_DW{1'b0}};
      break_mask_b <= {`DBC_DW{1'b0}};
    end else if (in_tlr) begin
      debug_control_reg <= `DBC_CTRL_RST;
    end else if (upd_dr && !is_read) begin
      case (sel)
        `DBC_SEL_CTRL: debug_control_reg <= dr_sh;
        `DBC_SEL_BASE_A: break_base_a <= dr_sh;
        `DBC_SEL_BASE_B: break_base_b <= dr_sh;
        `DBC_SEL_MASK_A: break_mask_a <= dr_sh;
        `DBC_SEL_MASK_B: break_mask_b <= dr_sh;
        default: debug_control_reg <= debug_control_reg;
      endcase
    end
  end

  // trace counter: software load wins over a decrement in the same cycle
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trace_counter <= `DBC_TRACE_RST;
    end else if (upd_dr && !is_read && sel == `DBC_SEL_TRACE) begin
      trace_counter <= dr_sh[`DBC_TRACE_W-1:0];
    end else if (debug_control_reg[`DBC_CTRL_TRACE_EN] && !cpu_halt_ack_i &&
      cpu_activity_status_i == `DBC_PS_EXEC && trace_counter != `DBC_TRACE_RST
      ) begin
      trace_counter <= trace_counter - `DBC_TRACE_ONE;
    end
  end

  assign trace_hit = debug_control_reg[`DBC_CTRL_TRACE_EN] &
    (trace_counter == `DBC_TRACE_RST);

  // address match under mask, optionally inverted for out-of-range
  assign hit_a = cpu_access_attributes_ok(debug_control_reg[`DBC_CTRL_BCA_HI:`DBC_CTRL_BCA_LO],
    cpu_access_attributes_i) & (debug_control_reg[`DBC_CTRL_RCA] ^
    (((cpu_addr_i ^ break_base_a) & ~break_mask_a) == {`DBC_DW{1'b0}}));
  assign hit_b = cpu_access_attributes_ok(debug_control_reg[`DBC_CTRL_BCB_HI:`DBC_CTRL_BCB_LO],
    cpu_access_attributes_i) & (debug_control_reg[`DBC_CTRL_RCB] ^
    (((cpu_addr_i ^ break_base_b) & ~break_mask_b) == {`DBC_DW{1'b0}}));

  // break request follows the access one cycle later
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_break_request_o <= 1'b0;
    end else begin
      cpu_break_request_o <= cpu_access_valid_i &
        (hit_a | hit_b);
    end
  end

  // halt sources; internal input is ignored unless enabled
  assign soft_halt_request_bit = debug_control_reg[`DBC_CTRL_SOFT];
  assign ihr_active = debug_control_reg[`DBC_CTRL_IHR_EN] &
    ~internal_halt_request_n_i;
  assign halt_src = soft_halt_request_bit | ihr_active | trace_hit;

  // request latched so a short source pulse is not lost before ack
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_halt_request_o <= 1'b0;
      lowpower_wake_o <= 1'b0;
    end else if (cpu_halt_ack_i) begin
      cpu_halt_request_o <= 1'b0;
      lowpower_wake_o <= 1'b0;
    end else if (halt_src) begin
      cpu_halt_request_o <= 1'b1;
      lowpower_wake_o <= 1'b1;
    end
  end

  // go pulses toward the cpu, issued only entering update-dr
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_go_o <= 1'b0;
      cpu_go_exit_o <= 1'b0;
    end else begin
      cpu_go_o <= go_now;
      cpu_go_exit_o <= go_exit_now;
    end
  end

  // session flag; a debug entry in the release cycle keeps it set
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      debug_session_o <= 1'b0;
    end else if (ack_rise) begin
      debug_session_o <= 1'b1;
    end else if (go_exit_now || in_tlr) begin
      debug_session_o <= 1'b0;
    end
  end

  // entry causes: sticky, set wins over the go+exit clear
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      brk_seen <= 1'b0;
      cause_flags <= `DBC_FLG_RST;
    end else begin
      if (cpu_break_request_o) begin
        brk_seen <= 1'b1;
      end else if (ack_rise) begin
        brk_seen <= 1'b0;
      end
      if (ack_rise) begin
        cause_flags <= cause_flags | {trace_hit, brk_seen,
          ~internal_halt_request_n_i & debug_control_reg[`DBC_CTRL_IHR_EN],
          soft_halt_request_bit};
      end else if (go_exit_now || in_tlr) begin
        cause_flags <= `DBC_FLG_RST;
      end
    end
  end

  // status read view: causes, cpu in debug, session
  assign debug_status_reg = {cause_flags, cpu_halt_ack_i, debug_session_o};
endmodule // dbc_top

// file: test/dbc_chk.sv
// Purpose: concurrent checks on the debug command block ports
// Assumes: one clock domain, asynchronous active-high reset
// Notes: attached to dbc_top by the bind at the foot
`timescale 1ns/10ps
module dbc_chk (
  input wire clk_sys_i,
  input wire rst_i,
  input wire cpu_halt_ack_i,
  input wire cpu_access_valid_i,
  input wire cpu_halt_request_o,
  input wire lowpower_wake_o,
  input wire cpu_break_request_o,
  input wire debug_session_o,
  input wire cpu_go_o,
  input wire cpu_go_exit_o,
  input wire [4:0] res_sel_o,
  input wire res_write_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // handshake steps
  sequence s_ack_seen;
    cpu_halt_request_o && cpu_halt_ack_i;
  endsequence
  sequence s_step_go;
    debug_session_o && cpu_go_o && !cpu_go_exit_o;
  endsequence
  a_wake_tracks: assert property (
    lowpower_wake_o == cpu_halt_request_o)
    else $error("wake differs from halt request");
  a_req_release: assert property (
    s_ack_seen |=> !cpu_halt_request_o)
    else $error("halt request kept after ack");
  a_session_set: assert property (
    $rose(cpu_halt_ack_i) |=> debug_session_o)
    else $error("session not set on debug entry");
  a_session_hold: assert property (
    $fell(debug_session_o) |-> cpu_go_exit_o || $past(cpu_go_exit_o)
      || $past(cpu_go_exit_o, 2))
    else $error("session dropped without go and exit");
  a_step_keeps: assert property (
    s_step_go |=> debug_session_o [*2])
    else $error("session dropped on single step");
  a_exit_with_go: assert property (
    cpu_go_exit_o |-> cpu_go_o)
    else $error("exit pulse without go");
  a_go_select: assert property (
    cpu_go_o |-> (res_sel_o == 5'h0b || res_sel_o == 5'h0c))
    else $error("go for a selection that forbids it");
  a_write_pulse: assert property (
    res_write_o |=> !res_write_o)
    else $error("resource write longer than one cycle");
  a_break_cause: assert property (
    cpu_break_request_o |-> $past(cpu_access_valid_i))
    else $error("break request without an access");
endmodule // dbc_chk
bind dbc_top dbc_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .cpu_halt_ack_i(cpu_halt_ack_i), .cpu_access_valid_i(cpu_access_valid_i),
  .cpu_halt_request_o(cpu_halt_request_o), .lowpower_wake_o(lowpower_wake_o),
  .cpu_break_request_o(cpu_break_request_o),
  .debug_session_o(debug_session_o), .cpu_go_o(cpu_go_o),
  .cpu_go_exit_o(cpu_go_exit_o), .res_sel_o(res_sel_o),
  .res_write_o(res_write_o));

// file: test/dbc_cpu_model.sv
// Purpose: behavioural cpu answering the halt handshake
// Assumes: same clock as the block
// Notes: delay_i sets how slowly the current instruction finishes
`timescale 1ns/10ps
module dbc_cpu_model (
  input wire clk_sys_i,
  input wire rst_i,
  input wire halt_req_i,
  input wire go_i,
  input wire go_exit_i,
  input wire [3:0] delay_i,
  output reg ack_o
);
  reg [3:0] wait_cnt;
  reg step;
  // finish the instruction, then sit in debug state until go
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      step <= 1'b0;
    end else if (go_i) begin
      ack_o <= 1'b0;
      step <= !go_exit_i;
      wait_cnt <= 4'h0;
    end else if (!ack_o && (halt_req_i || step)) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= delay_i) begin
        ack_o <= 1'b1;
        step <= 1'b0;
      end
    end
  end
endmodule // dbc_cpu_model

// file: test/tb.sv
// Purpose: self-checking bench for the debug command block
// Assumes: tck period 200 ns, pins driven on the falling clk edge
// Notes: go pulses are counted since scans outlast them
`timescale 1ns/10ps
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg tck = 1'b0;
  reg tms = 1'b1;
  reg tdi = 1'b0;
  reg ihr_n = 1'b1;
  reg vld = 1'b0;
  reg [31:0] adr = 32'h0;
  reg [3:0] att = 4'h0;
  reg [3:0] pst = 4'h0;
  reg [3:0] dly = 4'h2;
  reg [31:0] q;
  wire tdo, oe_n, halt, brk, sess, go, gox, wr, ack;
  wire [4:0] sel;
  wire [3:0] mon = {sess, ack, halt, brk};
  integer n_fail = 0;
  integer check_count = 0;
  integer n_go = 0;
  integer n_gox = 0;
  dbc_top dut (.clk_sys_i(clk), .rst_i(rst), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(1'b1), .internal_halt_request_n_i(ihr_n),
    .cpu_halt_ack_i(ack), .cpu_access_valid_i(vld), .cpu_addr_i(adr),
    .cpu_access_attributes_i(att), .cpu_activity_status_i(pst),
    .res_rdata_i(32'h0), .tdo_o(tdo), .tdo_oe_n_o(oe_n),
    .cpu_halt_request_o(halt), .lowpower_wake_o(),
    .cpu_break_request_o(brk), .debug_session_o(sess), .cpu_go_o(go),
    .cpu_go_exit_o(gox), .res_sel_o(sel), .res_capture_o(),
    .res_write_o(wr), .res_wdata_o());
  dbc_cpu_model cpu (.clk_sys_i(clk), .rst_i(rst), .halt_req_i(halt),
    .go_i(go), .go_exit_i(gox), .delay_i(dly), .ack_o(ack));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // pulses last one cycle, too short to poll between scans
  always @(posedge clk) begin
    n_go <= n_go + go;
    n_gox <= n_gox + gox;
  end
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(negedge clk);
    end
  endtask
  // bounded wait on one monitored output
  task wt(input [1:0] k, input v);
    integer i;
    begin
      i = 0;
      while (mon[k] !== v && i < 400) begin
        @(negedge clk);
        i = i + 1;
      end
      if (mon[k] !== v) begin
        n_fail = n_fail + 1;
        $display("mismatch wait %0d expected %b seen %b", k, v, mon[k]);
        final_report;
      end
    end
  endtask
  // one tck period; tdo sampled late in the high half, before it moves
  task tk(input m, input d, output o);
    begin
      tms = m;
      tdi = d;
      idle(2);
      tck = 1'b1;
      idle(4);
      o = tdo;
      tck = 1'b0;
      idle(2);
    end
  endtask
  task walk(input [3:0] p, input integer n);
    integer i;
    reg b;
    begin
      for (i = 0; i < n; i = i + 1)
        tk(p[i], 1'b0, b);
    end
  endtask
  // ir or dr scan from run-test-idle back to run-test-idle, lsb first
  task scan(input is_ir, input [31:0] d, input integer n);
    integer i;
    reg b;
    begin
      walk(is_ir ? 4'h3 : 4'h1, is_ir ? 4 : 3);
      q = 32'h0;
      for (i = 0; i < n; i = i + 1) begin
        tk(i == n - 1, d[i], b);
        q[i] = b;
      end
      walk(4'h1, 2);
    end
  endtask
  task cmd(input [7:0] c);
    begin
      scan(1'b1, {24'h0, c}, 8);
    end
  endtask
  task wreg(input [4:0] s, input [31:0] d);
    begin
      cmd({3'b000, s});
      scan(1'b0, d, 32);
    end
  endtask
  task t_regs;
    integer i;
    reg [14:0] cs;
    begin
      cs = {5'h1f, 5'h0c, 5'h1f};
      chk("sel", 32'h0c, sel);
      chk("oe_n", 32'h1, oe_n);
      wreg(5'h0d, 32'h00000c63);
      cmd(8'h8d);
      scan(1'b0, 32'h0, 32);
      chk("ctrl", 32'h00000c63, q);
      for (i = 0; i < 3; i = i + 1) begin
        cmd({3'b100, cs[i*5 +: 5]});
        scan(1'b0, 32'h0a5, 9);
        chk("bypass", 32'h14a, q);
      end
      wreg(5'h0d, 32'h0);
      $display("test regs done");
    end
  endtask
  task t_halt;
    begin
      ihr_n = 1'b0;
      idle(20);
      chk("halt_off", 32'h0, halt);
      wreg(5'h0d, 32'h00004000);
      wt(2'd2, 1'b1);
      idle(3);
      chk("halt_ack", 32'h0, halt);
      chk("sess", 32'h1, sess);
      cmd(8'h8e);
      scan(1'b0, 32'h0, 32);
      chk("stat", 32'h0b, q);
      ihr_n = 1'b1;
      wreg(5'h0d, 32'h0);
      $display("test halt done");
    end
  endtask
  task t_go;
    integer g0;
    integer x0;
    begin
      g0 = n_go;
      x0 = n_gox;
      cmd(8'h4b);
      scan(1'b0, 32'h0, 32);
      chk("go_step", g0 + 1, n_go);
      chk("exit_step", x0, n_gox);
      wt(2'd2, 1'b1);
      chk("sess_step", 32'h1, sess);
      cmd(8'he3);
      scan(1'b0, 32'h0, 32);
      chk("trace", 32'h0, q);
      cmd(8'h6c);
      idle(20);
      chk("go_none", g0 + 1, n_go);
      scan(1'b0, 32'h0, 1);
      chk("go_exit", g0 + 2, n_go);
      chk("exit", x0 + 1, n_gox);
      wt(2'd3, 1'b0);
      $display("test go done");
    end
  endtask
  task t_brk;
    integer i;
    begin
      wreg(5'h07, 32'h00001000);
      wreg(5'h09, 32'h0);
      wreg(5'h0d, 32'h00000005);
      for (i = 0; i < 3; i = i + 1) begin
        adr = (i == 2) ? 32'h2000 : 32'h1000;
        att = (i == 1) ? 4'h0 : 4'h2;
        vld = 1'b1;
        idle(1);
        vld = 1'b0;
        chk("brk", i == 0, brk);
        idle(2);
      end
      wreg(5'h0d, 32'h0);
      $display("test break done");
    end
  endtask
  task t_trace;
    begin
      wreg(5'h03, 32'h2);
      wreg(5'h0d, 32'h00002000);
      dly = 4'h9;
      pst = 4'h1;
      idle(20);
      chk("halt_trace", 32'h0, halt);
      pst = 4'h2;
      idle(2);
      pst = 4'h0;
      wt(2'd1, 1'b1);
      wt(2'd3, 1'b1);
      $display("test trace done");
    end
  endtask
  // main sequence
  initial begin
    idle(12);
    rst = 1'b0;
    idle(6);
    walk(4'h0, 1);
    t_regs;
    t_halt;
    t_go;
    t_brk;
    t_trace;
    final_report;
  end
endmodule // tb
